// *** core/count_step.sv ***
// next count value for one up or down step, decade or binary variant
// purely combinational; the caller decides whether the step is taken
`timescale 1ns/10ps
`default_nettype none
module count_step
   import updown_counter_pkg::*;
#(
   parameter bit DECADE = 1'b1
) (
   input wire logic [3:0] count,
   input wire logic up,
   output logic [3:0] next_count
);

   logic [3:0] top;

   assign top = DECADE ? DEC_MAX : BIN_MAX;

   always_comb begin
      next_count = count;
      if (up) begin
         // values above nine in the decade variant fall straight to zero
         if (count >= top) begin
            next_count = CNT_ZERO;
         end else begin
            next_count = count + CNT_ONE;
         end
      end else begin
         if (count == CNT_ZERO) begin
            next_count = top;
         end else begin
            // illegal decade values step down by one, reaching the legal range at nine
            next_count = count - CNT_ONE;
         end
      end
   end

endmodule // count_step
`default_nettype wire

// *** core/updown_counter.sv ***
// four-bit synchronous up/down counter, decade or binary variant,
// with cascade enables, terminal count, clocked carry and an AXI4-Lite side port
// assumes control pins come from logic on aclk; master_clear_n may be asynchronous
//
// What this block does
// - decade variant counts 0..9, wraps nine to zero up and zero to nine down.
// - binary variant counts 0..15, wrapping fifteen to zero and back.
// - state changes only on the rising clock edge, except master clear.
// - priority is async clear, sync clear, load, count, hold.
// - master clear low forces count to zero at once, without a clock.
// - sync clear low zeroes the count at the next rising edge.
// - load enable low captures the parallel data at the next edge.
// - count only when both count enables are low; otherwise hold.
// - direction high increments, low decrements.
// - terminal count low when trickle enable low and count at end of range.
// - terminal count stays low until count, direction or trickle enable changes.
// - clocked carry pulses low during clock low when carry conditions hold.
// - output enable low raises data_out_oe; high lowers it while data_out stays driven, counting continues.
// - four-bit counter, variant chosen at build time.
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module updown_counter
   import updown_counter_pkg::*;
#(
   parameter bit DECADE = 1'b1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic master_clear_n,
   input wire logic sync_clear_n,
   input wire logic load_enable_n,
   input wire logic count_enable_par_n,
   input wire logic count_enable_trickle_n,
   input wire logic count_up,
   input wire logic output_enable_n,
   input wire logic [3:0] data_in,
   output logic [3:0] data_out,
   output logic data_out_oe,
   output logic terminal_count_n,
   output logic clocked_carry_n,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // counter state
   logic [3:0] count_q;
   logic [3:0] count_d;
   logic [3:0] step_value;
   logic [3:0] top_value;
   mode_e mode;

   // software side controls
   logic sw_clear_q;
   logic sw_clear_d;
   logic sw_load_q;
   logic sw_load_d;
   logic [3:0] load_val_q;
   logic [3:0] load_val_d;

   // bus response state
   logic bvalid_q;
   logic bvalid_d;
   logic [1:0] bresp_q;
   logic [1:0] bresp_d;
   logic rvalid_q;
   logic rvalid_d;
   logic [1:0] rresp_q;
   logic [1:0] rresp_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;

   logic clear_req;
   logic load_req;
   logic count_req;
   logic tc_internal;
   logic wr_go;
   logic rd_go;
   logic [31:0] status_word;

   // address decode, one set for the write path and one for the read path
   logic wr_ctrl_hit;
   logic wr_load_hit;
   logic wr_bad_addr;
   logic rd_load_hit;
   logic rd_status_hit;
   logic rd_bad_addr;

   assign top_value = DECADE ? DEC_MAX : BIN_MAX;

   count_step #(
      .DECADE(DECADE)
   ) u_step (
      .count(count_q),
      .up(count_up),
      .next_count(step_value)
   );

   // software pulses join the pin requests for exactly one edge
   assign clear_req = ~sync_clear_n | sw_clear_q;
   assign load_req = ~load_enable_n | sw_load_q;
   assign count_req = ~count_enable_par_n & ~count_enable_trickle_n;

   always_comb begin
      if (clear_req) begin
         mode = MODE_CLEAR;
      end else if (load_req) begin
         mode = MODE_LOAD;
      end else if (count_req) begin
         mode = MODE_COUNT;
      end else begin
         mode = MODE_HOLD;
      end
   end

   always_comb begin
      case (mode)
         MODE_CLEAR: begin
            count_d = CNT_ZERO;
         end
         MODE_LOAD: begin
            // the pin load wins over a software load in the same cycle
            count_d = ~load_enable_n ? data_in : load_val_q;
         end
         MODE_COUNT: begin
            count_d = step_value;
         end
         MODE_HOLD: begin
            count_d = count_q;
         end
         default: begin
            count_d = count_q;
         end
      endcase
   end

   // master clear acts without the clock and over everything else
   always_ff @(posedge aclk or negedge master_clear_n) begin
      if (!master_clear_n) begin
         count_q <= CNT_ZERO;
      end else if (!aresetn) begin
         count_q <= CNT_ZERO;
      end else begin
         count_q <= count_d;
      end
   end

   // terminal count follows state, direction and trickle enable combinationally,
   // so it stays low exactly as long as those three hold still
   always_comb begin
      tc_internal = 1'b0;
      if (!count_enable_trickle_n) begin
         if (count_up && count_q == top_value) begin
            tc_internal = 1'b1;
         end else if (!count_up && count_q == CNT_ZERO) begin
            tc_internal = 1'b1;
         end
      end
   end

   assign terminal_count_n = ~tc_internal;

   // clocked carry is gated by the clock low phase so it cannot carry the
   // decode spikes of terminal count; this is the output meant for clocking
   assign clocked_carry_n = ~(~aclk & sync_clear_n & load_enable_n & ~count_enable_par_n &
      ~count_enable_trickle_n & tc_internal);

   assign data_out = count_q;
   assign data_out_oe = ~output_enable_n;

   // register bus: write address and data are taken together, one at a time
   assign wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign rd_go = s_axi_arvalid & ~rvalid_q;
   assign s_axi_arready = rd_go;

   // unaligned or unmapped addresses match nothing and answer with an error,
   // so a stray access can never pulse a clear or a load
   assign wr_ctrl_hit = (s_axi_awaddr == CTRL_OFF);
   assign wr_load_hit = (s_axi_awaddr == LOAD_OFF);
   assign wr_bad_addr = ~wr_ctrl_hit & ~wr_load_hit & (s_axi_awaddr != STATUS_OFF);
   assign rd_load_hit = (s_axi_araddr == LOAD_OFF);
   assign rd_status_hit = (s_axi_araddr == STATUS_OFF);
   assign rd_bad_addr = ~rd_load_hit & ~rd_status_hit & (s_axi_araddr != CTRL_OFF);

   always_comb begin
      status_word = RDATA_RESET;
      status_word[STAT_CNT_LSB +: CNT_W] = count_q;
      status_word[STAT_TC_BIT] = terminal_count_n;
      status_word[STAT_UP_BIT] = count_up;
      status_word[STAT_OE_BIT] = data_out_oe;
      status_word[STAT_DEC_BIT] = DECADE;
   end

   // a write to the status word is accepted and dropped with an okay answer;
   // the control bits are one-edge pulses, they never stick
   always_comb begin
      sw_clear_d = 1'b0;
      sw_load_d = 1'b0;
      load_val_d = load_val_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      if (wr_go) begin
         bvalid_d = 1'b1;
         bresp_d = RESP_OKAY;
         if (wr_ctrl_hit) begin
            if (s_axi_wstrb[0]) begin
               sw_clear_d = s_axi_wdata[CTRL_CLR_BIT];
               sw_load_d = s_axi_wdata[CTRL_LOAD_BIT];
            end
         end else if (wr_load_hit) begin
            if (s_axi_wstrb[0]) begin
               load_val_d = s_axi_wdata[3:0];
            end
         end else if (wr_bad_addr) begin
            bresp_d = RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sw_clear_q <= 1'b0;
         sw_load_q <= 1'b0;
         load_val_q <= LOAD_RESET;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else begin
         sw_clear_q <= sw_clear_d;
         sw_load_q <= sw_load_d;
         load_val_q <= load_val_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
      end
   end

   // the control word holds only pulses, so it reads back as zero;
   // read data is registered so it stands unchanged until rready
   always_comb begin
      rvalid_d = rvalid_q;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
      if (rd_go) begin
         rvalid_d = 1'b1;
         rresp_d = RESP_OKAY;
         rdata_d = RDATA_RESET;
         if (rd_load_hit) begin
            rdata_d[3:0] = load_val_q;
         end else if (rd_status_hit) begin
            rdata_d = status_word;
         end else if (rd_bad_addr) begin
            rresp_d = RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= RDATA_RESET;
      end else begin
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;

endmodule // updown_counter
`default_nettype wire

// *** core/updown_counter_pkg.sv ***
// constants shared by the up/down counter core and its next-state helper
// assumes a single 200 MHz clock and an AXI4-Lite master on the register side
package updown_counter_pkg;

   localparam int CNT_W = 4;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] DEC_MAX = 4'h9;
   localparam logic [3:0] BIN_MAX = 4'hF;
   localparam logic [3:0] CNT_ONE = 4'h1;

   // register map, byte addresses on a 4-bit AXI4-Lite address
   localparam int ADDR_W = 4;
   localparam logic [3:0] CTRL_OFF = 4'h0;
   localparam logic [3:0] LOAD_OFF = 4'h4;
   localparam logic [3:0] STATUS_OFF = 4'h8;

   // control register fields (write-one pulses)
   localparam int CTRL_CLR_BIT = 0;
   localparam int CTRL_LOAD_BIT = 1;

   // status register fields
   localparam int STAT_CNT_LSB = 0;
   localparam int STAT_TC_BIT = 4;
   localparam int STAT_UP_BIT = 5;
   localparam int STAT_OE_BIT = 6;
   localparam int STAT_DEC_BIT = 7;

   localparam logic [3:0] LOAD_RESET = 4'h0;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // operating mode, gray coded along hold -> count -> load -> clear
   typedef enum logic [1:0] {
      MODE_HOLD = 2'b00,
      MODE_COUNT = 2'b01,
      MODE_LOAD = 2'b11,
      MODE_CLEAR = 2'b10
   } mode_e;

endpackage

// *** test/cascade_stage.sv ***
// far-side stage: a register clocked by the carry and a next stage enabled by terminal count
// assumes one counter stage in front on the same aclk
`timescale 1ns/10ps
`default_nettype none
module cascade_stage (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic terminal_count_n,
   input wire logic clocked_carry_n,
   output logic [7:0] carry_ticks,
   output logic [7:0] tc_ticks
);
   // terminal count may spike, so only the clocked carry serves as a clock
   always_ff @(posedge clocked_carry_n or negedge aresetn) begin
      if (!aresetn)
         carry_ticks <= 8'h00;
      else
         carry_ticks <= carry_ticks + 8'h01;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn)
         tc_ticks <= 8'h00;
      else if (!terminal_count_n)
         tc_ticks <= tc_ticks + 8'h01;
   end
endmodule // cascade_stage
`default_nettype wire

// *** test/test_updown_counter.sv ***
// self-checking bench: random pin traffic, register access, far-side cascade stage
// assumes the decade build of the counter
`timescale 1ns/10ps
`default_nettype none
module test_updown_counter;
   import updown_counter_pkg::*;
   logic aclk = 1'h0, aresetn = 1'h1, master_clear_n = 1'h1, sync_clear_n = 1'h1;
   logic load_enable_n = 1'h1, count_enable_par_n = 1'h1, count_enable_trickle_n = 1'h1;
   logic count_up = 1'h0, output_enable_n = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [3:0] data_in = 4'h0, s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, exp, data_out;
   logic [3:0] exp_b, bin_out;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic data_out_oe, terminal_count_n, clocked_carry_n, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] carry_ticks, tc_ticks, c0, t0;
   int bad_count = 0, check_count = 0, n_cc = 0, n_tc = 0;
   updown_counter #(.DECADE(1'h1)) i_updown_counter (.aclk, .aresetn, .master_clear_n,
      .sync_clear_n, .load_enable_n, .count_enable_par_n, .count_enable_trickle_n, .count_up,
      .output_enable_n, .data_in, .data_out, .data_out_oe, .terminal_count_n, .clocked_carry_n,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   // binary build on the same pins; its bus side stays idle
   updown_counter #(.DECADE(1'h0)) i_updown_counter_bin (.aclk, .aresetn, .master_clear_n,
      .sync_clear_n, .load_enable_n, .count_enable_par_n, .count_enable_trickle_n, .count_up,
      .output_enable_n, .data_in, .data_out(bin_out), .data_out_oe(), .terminal_count_n(),
      .clocked_carry_n(), .s_axi_awaddr(4'h0), .s_axi_awvalid(1'h0), .s_axi_awready(),
      .s_axi_wdata(32'h0), .s_axi_wstrb(4'h0), .s_axi_wvalid(1'h0), .s_axi_wready(),
      .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(1'h1), .s_axi_araddr(4'h0),
      .s_axi_arvalid(1'h0), .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(),
      .s_axi_rready(1'h1));
   cascade_stage i_cascade_stage (.aclk, .aresetn, .terminal_count_n, .clocked_carry_n,
      .carry_ticks, .tc_ticks);
   initial forever #2.5 aclk = ~aclk;
   function automatic logic tcn(input logic [3:0] c);
      return !(!count_enable_trickle_n && (count_up ? c == DEC_MAX : c == 4'h0));
   endfunction
   function automatic logic [3:0] nxt(input logic [3:0] c, input logic [3:0] m);
      if (!master_clear_n || !sync_clear_n) return 4'h0;
      if (!load_enable_n) return data_in;
      if (count_enable_par_n || count_enable_trickle_n) return c;
      if (count_up) return (c >= m) ? 4'h0 : c + 4'h1;
      return (c == 4'h0) ? m : c - 4'h1;
   endfunction
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         $display("unexpected %s: expected %h seen %h", s, e, g);
         bad_count++;
      end
   endtask
   task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
      s_axi_awvalid <= 1'h0;
      s_axi_wvalid <= 1'h0;
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      chk("bresp", 32'(er), 32'(s_axi_bresp));
   endtask
   task automatic axr(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
      chk("rresp", 32'(er), 32'(s_axi_rresp));
      if (er == RESP_OKAY) chk("rdata", ed, s_axi_rdata);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge aclk);
      bad_count++;
      summarize();
   end
   initial begin
      aresetn <= 1'h0;
      void'($urandom(61));
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      exp = 4'h0;
      exp_b = 4'h0;
      @(posedge aclk);
      c0 = carry_ticks;
      t0 = tc_ticks;
      repeat (700) begin
         @(posedge aclk);
         // tallies use the levels that this edge samples, before new values land
         if (!tcn(exp)) n_tc++;
         if (sync_clear_n && load_enable_n && !count_enable_par_n && !tcn(exp)) n_cc++;
         exp = nxt(exp, DEC_MAX);
         exp_b = nxt(exp_b, BIN_MAX);
         master_clear_n <= ($urandom % 16) != 0;
         sync_clear_n <= ($urandom % 10) != 0;
         load_enable_n <= ($urandom % 6) != 0;
         count_enable_par_n <= ($urandom % 6) == 0;
         count_enable_trickle_n <= ($urandom % 6) == 0;
         count_up <= count_up ^ (($urandom % 12) == 0);
         output_enable_n <= ($urandom % 2) != 0;
         data_in <= 4'($urandom);
         #1;
         if (!master_clear_n) exp = 4'h0;
         if (!master_clear_n) exp_b = 4'h0;
         chk("bin count", 32'(exp_b), 32'(bin_out));
         chk("count", 32'(exp), 32'(data_out));
         chk("tc", 32'(tcn(exp)), 32'(terminal_count_n));
         chk("oe", 32'(!output_enable_n), 32'(data_out_oe));
         chk("cc high", 32'h1, 32'(clocked_carry_n));
         @(negedge aclk);
         #1 chk("cc low", 32'(!(sync_clear_n && load_enable_n && !count_enable_par_n && !tcn(exp))), 32'(clocked_carry_n));
      end
      chk("carry ticks", 32'(8'(n_cc)), 32'(8'(carry_ticks - c0)));
      chk("tc ticks", 32'(8'(n_tc)), 32'(8'(tc_ticks - t0)));
      @(posedge aclk);
      master_clear_n <= 1'h1;
      sync_clear_n <= 1'h1;
      load_enable_n <= 1'h1;
      count_enable_trickle_n <= 1'h1;
      count_up <= 1'h1;
      output_enable_n <= 1'h0;
      axw(LOAD_OFF, 32'h7, RESP_OKAY);
      axr(LOAD_OFF, 32'h7, RESP_OKAY);
      axw(CTRL_OFF, 32'h2, RESP_OKAY);
      axr(STATUS_OFF, 32'hF7, RESP_OKAY);
      axw(STATUS_OFF, 32'h0, RESP_OKAY);
      axw(CTRL_OFF, 32'h1, RESP_OKAY);
      axr(STATUS_OFF, 32'hF0, RESP_OKAY);
      axw(4'hC, 32'h1, RESP_SLVERR);
      axr(4'hC, 32'h0, RESP_SLVERR);
      summarize();
   end
endmodule // test_updown_counter
`default_nettype wire

// *** test/updown_counter_assertions.sv ***
// pin-level checker for the up/down counter, bound onto the core
// assumes pins move just after aclk edges; a bus clear or load may act on the count
`timescale 1ns/10ps
`default_nettype none
module updown_counter_checker
   import updown_counter_pkg::*;
#(
   parameter bit DECADE = 1'h1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic master_clear_n,
   input wire logic sync_clear_n,
   input wire logic load_enable_n,
   input wire logic count_enable_par_n,
   input wire logic count_enable_trickle_n,
   input wire logic count_up,
   input wire logic output_enable_n,
   input wire logic [3:0] data_in,
   input wire logic [3:0] data_out,
   input wire logic data_out_oe,
   input wire logic terminal_count_n,
   input wire logic clocked_carry_n,
   input wire logic s_axi_bvalid
);
   localparam logic [3:0] MX = DECADE ? DEC_MAX : BIN_MAX;
   logic pins;
   logic cnt;
   logic [3:0] step;
   // a bus clear or load lands while bvalid is up, so those edges are skipped
   assign pins = master_clear_n & sync_clear_n & ~s_axi_bvalid;
   assign cnt = pins & load_enable_n & ~count_enable_par_n & ~count_enable_trickle_n;
   assign step = count_up ? data_out + 4'h1 : data_out - 4'h1;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_MCLR: assert property (!master_clear_n |-> data_out == CNT_ZERO)
      else $error("master clear");
   AST_SCLR: assert property (master_clear_n && !sync_clear_n |=> data_out == CNT_ZERO)
      else $error("sync clear");
   AST_LOAD: assert property (pins && !load_enable_n |=> !master_clear_n || data_out == $past(data_in))
      else $error("load");
   AST_HOLD: assert property (pins && load_enable_n && (count_enable_par_n || count_enable_trickle_n)
      |=> !master_clear_n || $stable(data_out)) else $error("hold");
   AST_STEP: assert property (cnt && (count_up ? data_out < MX : data_out != CNT_ZERO)
      |=> !master_clear_n || data_out == $past(step)) else $error("step");
   AST_WRAP_UP: assert property (cnt && count_up && data_out >= MX |=> !master_clear_n || data_out == CNT_ZERO)
      else $error("wrap up");
   AST_WRAP_DN: assert property (cnt && !count_up && data_out == CNT_ZERO |=> !master_clear_n || data_out == MX)
      else $error("wrap down");
   AST_TC: assert property (terminal_count_n == !(!count_enable_trickle_n &&
      (count_up ? data_out == MX : data_out == CNT_ZERO))) else $error("tc");
   AST_OE: assert property (data_out_oe != output_enable_n) else $error("oe");
   AST_CC: assert property (clocked_carry_n == !(sync_clear_n && load_enable_n &&
      !count_enable_par_n && !terminal_count_n)) else $error("carry low");
   AST_CC_HI: assert property (@(negedge aclk) clocked_carry_n) else $error("carry high");
   cover property (cnt && count_up && data_out == MX);
   cover property (pins && !load_enable_n);
   cover property (!clocked_carry_n);
endmodule // updown_counter_checker
bind updown_counter updown_counter_checker #(.DECADE(DECADE)) i_updown_counter_checker (
   .aclk, .aresetn, .master_clear_n, .sync_clear_n, .load_enable_n, .count_enable_par_n,
   .count_enable_trickle_n, .count_up, .output_enable_n, .data_in, .data_out, .data_out_oe,
   .terminal_count_n, .clocked_carry_n, .s_axi_bvalid);
`default_nettype wire
